// ===== verilog/ccv_defs.svh
// Offsets, field positions, reset values and masks of the
// capture/compare value block. Included by its bare name.
`ifndef CCV_DEFS_SVH
`define CCV_DEFS_SVH

// ==========================================================
// Register byte offsets
`define CCV_OFF_MODE_A       8'h18
`define CCV_OFF_MODE_B       8'h1C
`define CCV_OFF_CAPTURE_EN   8'h20
`define CCV_OFF_CH1_VALUE    8'h34
`define CCV_OFF_CH2_VALUE    8'h38
`define CCV_OFF_CH3_VALUE    8'h3C

// ==========================================================
// Reset values
`define CCV_VALUE_RESET      32'h0000_0000
`define CCV_MODE_RESET       32'h0000_0000
`define CCV_CAPEN_RESET      32'h0000_0000

// ==========================================================
// Field positions
`define CCV_A_CH1_INPUT      0
`define CCV_A_CH1_PRELOAD    3
`define CCV_A_CH2_INPUT      8
`define CCV_A_CH2_PRELOAD    11
`define CCV_B_CH3_INPUT      0
`define CCV_B_CH3_PRELOAD    3
`define CCV_CAPEN_CH1        0
`define CCV_CAPEN_CH2        4
`define CCV_CAPEN_CH3        8

// ==========================================================
// Implemented-bit masks
`define CCV_MODE_A_MASK      32'h0000_0909
`define CCV_MODE_B_MASK      32'h0000_0009
`define CCV_CAPEN_MASK       32'h0000_0111
`define CCV_NARROW_MASK      32'h0000_FFFF
`define CCV_WIDE_MASK        32'hFFFF_FFFF

`endif

// ===== verilog/ccv_pkg.sv
// Types shared by the capture/compare value block.
// Assumes nothing of its surroundings.
package ccv_pkg;

    // ======================================================
    // Per-channel configuration carrier
    typedef struct packed {
        logic is_input;
        logic preload_en;
        logic capture_en;
    } chan_cfg_t;

endpackage : ccv_pkg

// ===== verilog/ccv_channel.sv
// One capture/compare channel: preload, active compare value
// and match output. Assumes counter and events synchronous to
// pclk, each event a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "ccv_defs.svh"

module ccv_channel #(
    parameter logic [31:0] VALUE_MASK = `CCV_WIDE_MASK
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire ccv_pkg::chan_cfg_t cfg,
    input  wire logic              sw_write,
    input  wire logic [31:0]       wdata,
    input  wire logic              update_event,
    input  wire logic              capture_event,
    input  wire logic [31:0]       timer_counter,
    output logic      [31:0]       value,
    output logic                   compare_out
);

    logic [31:0] preload_r;
    logic [31:0] preload_nxt;
    logic [31:0] active_r;
    logic [31:0] active_nxt;
    logic        match_r;
    logic        match_nxt;
    logic [31:0] cnt_m;

    assign cnt_m = timer_counter & VALUE_MASK;

    // ======================================================
    // Next state
    always_comb begin
        preload_nxt = preload_r;
        active_nxt  = active_r;
        match_nxt   = (cnt_m == active_r);
        if (cfg.is_input) begin
            // Writes are dropped here so a capture is kept
            if (capture_event && cfg.capture_en) begin
                preload_nxt = cnt_m;
            end
        end else begin
            if (update_event && cfg.preload_en) begin
                active_nxt = preload_r;
            end
            if (sw_write) begin
                preload_nxt = wdata & VALUE_MASK;
                if (!cfg.preload_en) begin
                    active_nxt = wdata & VALUE_MASK;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            preload_r <= `CCV_VALUE_RESET;
            active_r  <= `CCV_VALUE_RESET;
            match_r   <= 1'b0;
        end else begin
            preload_r <= preload_nxt;
            active_r  <= active_nxt;
            match_r   <= match_nxt;
        end
    end

    assign value       = preload_r;
    assign compare_out = match_r;

    // ======================================================
    // Checks
    chk_direct_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        (sw_write && !cfg.is_input && !cfg.preload_en)
        |=> (active_r == ($past(wdata) & VALUE_MASK)))
        else $error("direct write did not reach active value");

    chk_update_xfer: assert property (
        @(posedge pclk) disable iff (!presetn)
        (update_event && cfg.preload_en && !cfg.is_input)
        |=> (active_r == $past(preload_r)))
        else $error("update did not move preload to active");

    chk_preload_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg.preload_en && !update_event)
        |=> $stable(active_r))
        else $error("active value moved without update");

    // Starts only from edges seen out of reset: the match flop is
    // still held clear at the edge on which reset is released
    chk_match_out: assert property (
        @(posedge pclk) disable iff (!presetn)
        presetn |=> (compare_out ==
                  ($past(cnt_m) == $past(active_r))))
        else $error("compare output wrong");

    chk_capture_latch: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg.is_input && cfg.capture_en && capture_event)
        |=> (value == $past(cnt_m)))
        else $error("capture did not latch counter");

    chk_capture_gate: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg.is_input && !(cfg.capture_en && capture_event))
        |=> $stable(value))
        else $error("input value changed without capture");

    chk_upper_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((value & ~VALUE_MASK) == 32'h0000_0000) &&
        ((active_r & ~VALUE_MASK) == 32'h0000_0000))
        else $error("unimplemented upper bits set");

endmodule : ccv_channel
`default_nettype wire

// ===== verilog/capture_compare_value_regs.sv
// Capture/compare value registers of timer channels 1 to 3,
// reached over APB, with the mode and capture-enable bits.
// Assumes counter, update and capture events synchronous to
// pclk; events are one-cycle pulses.
//
// Behaviour
// - Output mode: software write loads the preload value.
// - Preload disabled: written value goes straight to active compare.
// - Preload enabled: preload moves to active only on update event.
// - Active value compared with counter, match shown on channel output.
// - Input mode: register holds counter latched at last capture.
// - Preloads of ch1, ch2 from mode reg a; ch3 from mode reg b.
// - Upper half exists only on the wide instance.
// - All value registers reset to zero.
// - Capture latches only while the channel capture enable is set.
`timescale 1ns/1ps
`default_nettype none
`include "ccv_defs.svh"

module capture_compare_value_regs #(
    parameter bit WIDE_INSTANCE = 1'b1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] timer_counter,
    input  wire logic        update_event,
    input  wire logic        ch1_capture_event,
    input  wire logic        ch2_capture_event,
    input  wire logic        ch3_capture_event,
    output logic             ch1_compare_out,
    output logic             ch2_compare_out,
    output logic             ch3_compare_out
);

    localparam logic [31:0] VALUE_MASK =
        WIDE_INSTANCE ? `CCV_WIDE_MASK : `CCV_NARROW_MASK;

    // ======================================================
    // APB slave state
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pready_r;
    logic        pready_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;
    logic [31:0] mode_a_r;
    logic [31:0] mode_a_nxt;
    logic [31:0] mode_b_r;
    logic [31:0] mode_b_nxt;
    logic [31:0] capen_r;
    logic [31:0] capen_nxt;

    logic        setup;
    logic        access_done;
    logic        wr_done;
    logic        hit;
    logic [31:0] rd_mux;
    logic [2:0]  wr_ch;
    logic [2:0]  cap_ev;
    logic [2:0]  cmp;
    logic [31:0] value [3];
    ccv_pkg::chan_cfg_t cfg [3];

    assign setup       = psel && !penable;
    // Only a completed access phase writes
    assign access_done = psel && penable && pready_r;
    assign wr_done     = access_done && pwrite;
    assign cap_ev      = {ch3_capture_event, ch2_capture_event,
                          ch1_capture_event};

    // ======================================================
    // Address decode and read mux
    always_comb begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `CCV_OFF_MODE_A:     rd_mux = mode_a_r;
            `CCV_OFF_MODE_B:     rd_mux = mode_b_r;
            `CCV_OFF_CAPTURE_EN: rd_mux = capen_r;
            `CCV_OFF_CH1_VALUE:  rd_mux = value[0];
            `CCV_OFF_CH2_VALUE:  rd_mux = value[1];
            `CCV_OFF_CH3_VALUE:  rd_mux = value[2];
            default:             hit    = 1'b0;
        endcase
    end

    always_comb begin
        wr_ch[0] = wr_done && (paddr == `CCV_OFF_CH1_VALUE);
        wr_ch[1] = wr_done && (paddr == `CCV_OFF_CH2_VALUE);
        wr_ch[2] = wr_done && (paddr == `CCV_OFF_CH3_VALUE);
    end

    // ======================================================
    // Bus answer and control registers
    always_comb begin
        prdata_nxt  = prdata_r;
        pslverr_nxt = pslverr_r;
        pready_nxt  = setup;
        mode_a_nxt  = mode_a_r;
        mode_b_nxt  = mode_b_r;
        capen_nxt   = capen_r;
        if (setup) begin
            // Read data sampled in setup: one cycle older than
            // the completing edge, a capture in between is missed
            prdata_nxt  = pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_nxt = !hit;
        end else if (access_done) begin
            pslverr_nxt = 1'b0;
        end
        if (wr_done) begin
            case (paddr)
                `CCV_OFF_MODE_A:
                    mode_a_nxt = pwdata & `CCV_MODE_A_MASK;
                `CCV_OFF_MODE_B:
                    mode_b_nxt = pwdata & `CCV_MODE_B_MASK;
                `CCV_OFF_CAPTURE_EN:
                    capen_nxt = pwdata & `CCV_CAPEN_MASK;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            mode_a_r  <= `CCV_MODE_RESET;
            mode_b_r  <= `CCV_MODE_RESET;
            capen_r   <= `CCV_CAPEN_RESET;
        end else begin
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            mode_a_r  <= mode_a_nxt;
            mode_b_r  <= mode_b_nxt;
            capen_r   <= capen_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // ======================================================
    // Channel configuration
    always_comb begin
        cfg[0].is_input   = mode_a_r[`CCV_A_CH1_INPUT];
        cfg[0].preload_en = mode_a_r[`CCV_A_CH1_PRELOAD];
        cfg[0].capture_en = capen_r[`CCV_CAPEN_CH1];
        cfg[1].is_input   = mode_a_r[`CCV_A_CH2_INPUT];
        cfg[1].preload_en = mode_a_r[`CCV_A_CH2_PRELOAD];
        cfg[1].capture_en = capen_r[`CCV_CAPEN_CH2];
        cfg[2].is_input   = mode_b_r[`CCV_B_CH3_INPUT];
        cfg[2].preload_en = mode_b_r[`CCV_B_CH3_PRELOAD];
        cfg[2].capture_en = capen_r[`CCV_CAPEN_CH3];
    end

    // ======================================================
    // Channels
    for (genvar i = 0; i < 3; i++) begin : g_ch
        ccv_channel #(
            .VALUE_MASK (VALUE_MASK)
        ) u_ch (
            .pclk          (pclk),
            .presetn       (presetn),
            .cfg           (cfg[i]),
            .sw_write      (wr_ch[i]),
            .wdata         (pwdata),
            .update_event  (update_event),
            .capture_event (cap_ev[i]),
            .timer_counter (timer_counter),
            .value         (value[i]),
            .compare_out   (cmp[i])
        );
    end

    assign ch1_compare_out = cmp[0];
    assign ch2_compare_out = cmp[1];
    assign ch3_compare_out = cmp[2];

    // ======================================================
    // Checks
    chk_apb_ready: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup |=> (pready && !$past(pready)))
        else $error("pready not one cycle after setup");

    chk_unmapped_err: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && !hit) |=> pslverr)
        else $error("unmapped access without error");

    chk_write_lands: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_done && paddr == `CCV_OFF_CH1_VALUE &&
         !cfg[0].is_input)
        |=> (value[0] == ($past(pwdata) & VALUE_MASK)))
        else $error("ch1 write did not load preload value");

    chk_input_ro: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_done && paddr == `CCV_OFF_CH2_VALUE &&
         cfg[1].is_input && !cap_ev[1])
        |=> $stable(value[1]))
        else $error("write changed input-mode value");

    chk_mode_source: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_done && paddr == `CCV_OFF_MODE_B)
        |=> (cfg[2].preload_en ==
             $past(pwdata[`CCV_B_CH3_PRELOAD])))
        else $error("ch3 preload not from mode reg b");

    chk_reset_value: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> (value[0] == `CCV_VALUE_RESET &&
                            value[1] == `CCV_VALUE_RESET &&
                            value[2] == `CCV_VALUE_RESET))
        else $error("value register not zero after reset");

endmodule : capture_compare_value_regs
`default_nettype wire

// ===== tb/ccv_pins_model.sv
// Model of the timer side: counter that the bench may freeze at a
// value, and one-cycle update and capture pulses on request.
// Assumes requests change just after rising edges of pclk.
`timescale 1ns/1ps
`default_nettype none

module ccv_pins_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        load,
    input  wire logic [31:0] load_val,
    input  wire logic [3:0]  ev_req,
    output logic      [31:0] timer_counter,
    output logic             update_event,
    output logic      [2:0]  capture_event
);
    // ==========================================================
    // Counter and event pulses
    // Registered, so a request of one cycle gives exactly one pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_counter <= 32'h0000_0000;
            update_event  <= 1'b0;
            capture_event <= 3'h0;
        end else begin
            timer_counter <= load ? load_val : timer_counter + 32'h0000_0001;
            update_event  <= ev_req[3];
            capture_event <= ev_req[2:0];
        end
    end
endmodule : ccv_pins_model
`default_nettype wire

// ===== tb/capture_compare_value_regs_tb.sv
// Self-checking bench of the capture/compare value block: APB master,
// timer model, and a narrow instance read beside the wide one.
// Assumes the design files and the timer model compile first.
`timescale 1ns/1ps
`default_nettype none
`include "ccv_defs.svh"

module capture_compare_value_regs_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        load, upd, err;
    logic [7:0]  paddr;
    logic [3:0]  ev_req;
    logic [2:0]  cap_ev, cmp;
    logic [31:0] pwdata, prdata, prdata_n, load_val, timer_counter;
    logic [31:0] rd, rd_n, seed, v, w, cap;
    int          fails, samples_checked;

    capture_compare_value_regs #(.WIDE_INSTANCE(1'b1)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_counter(timer_counter),
        .update_event(upd), .ch1_capture_event(cap_ev[0]),
        .ch2_capture_event(cap_ev[1]), .ch3_capture_event(cap_ev[2]),
        .ch1_compare_out(cmp[0]), .ch2_compare_out(cmp[1]),
        .ch3_compare_out(cmp[2]));

    // Narrow instance shares the bus; only its read data is watched
    capture_compare_value_regs #(.WIDE_INSTANCE(1'b0)) i_narrow (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_n),
        .pready(), .pslverr(), .timer_counter(timer_counter),
        .update_event(upd), .ch1_capture_event(cap_ev[0]),
        .ch2_capture_event(cap_ev[1]), .ch3_capture_event(cap_ev[2]),
        .ch1_compare_out(), .ch2_compare_out(), .ch3_compare_out());

    ccv_pins_model i_pins (
        .pclk(pclk), .presetn(presetn), .load(load), .load_val(load_val),
        .ev_req(ev_req), .timer_counter(timer_counter),
        .update_event(upd), .capture_event(cap_ev));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [7:0] addr(input int c);
        return 8'(`CCV_OFF_CH1_VALUE + 4 * c);
    endfunction : addr

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        rd_n    = prdata_n;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // One idle cycle, so a following call never drives psel twice
        @(posedge pclk);
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(32'(err), 32'h0000_0000);
        chk(rd, exp);
        chk(rd_n, exp & `CCV_NARROW_MASK);
    endtask : rdchk

    task automatic setmode(input int c, input logic inp, input logic pre);
        logic [31:0] f;
        f = {28'h0, pre, 2'b00, inp};
        apb(1'b1, `CCV_OFF_MODE_A, (c == 2) ? 32'h0 : f << (8 * c));
        apb(1'b1, `CCV_OFF_MODE_B, (c == 2) ? f : 32'h0);
    endtask : setmode

    // Pulse reaches the design one edge after the request
    task automatic ev(input logic [3:0] m);
        ev_req <= m;
        @(posedge pclk);
        ev_req <= 4'h0;
        @(posedge pclk);
        cap = timer_counter;
    endtask : ev

    task automatic finish_test;
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // ==========================================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        finish_test;
    end

    // ==========================================================
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, load} = 5'h00;
        paddr    = 8'h00;
        pwdata   = 32'h0000_0000;
        load_val = 32'h0000_0000;
        ev_req   = 4'h0;
        seed     = 32'h0001_034C;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 3; a++) rdchk(addr(a), 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        for (int c = 0; c < 3; c++) begin
            seed = lfsr(seed);
            v    = seed;
            seed = lfsr(seed);
            w    = seed;
            setmode(c, 1'b0, 1'b0);
            apb(1'b1, addr(c), v);
            rdchk(addr(c), v);
            load     <= 1'b1;
            load_val <= v;
            repeat (3) @(posedge pclk);
            chk(32'(cmp[c]), 32'h0000_0001);
            load_val <= v + 32'h0000_0001;
            repeat (3) @(posedge pclk);
            chk(32'(cmp[c]), 32'h0000_0000);
            setmode(c, 1'b0, 1'b1);
            apb(1'b1, addr(c), w);
            rdchk(addr(c), w);
            load_val <= w;
            repeat (3) @(posedge pclk);
            chk(32'(cmp[c]), 32'h0000_0000);
            ev(4'h8);
            repeat (2) @(posedge pclk);
            chk(32'(cmp[c]), 32'h0000_0001);
            setmode(c, 1'b1, 1'b0);
            ev(4'(1 << c));
            rdchk(addr(c), w);
            apb(1'b1, `CCV_OFF_CAPTURE_EN, 32'h0000_0001 << (4 * c));
            load <= 1'b0;
            ev(4'(1 << c));
            rdchk(addr(c), cap);
            apb(1'b1, addr(c), v);
            rdchk(addr(c), cap);
            apb(1'b1, `CCV_OFF_CAPTURE_EN, 32'h0000_0000);
        end
        finish_test;
    end
endmodule : capture_compare_value_regs_tb
`default_nettype wire
